// ### usb_endpoint_interrupt_summary.v
// Endpoint interrupt summary of a full-speed USB device controller.
// Assumes endpoint status sources come from another block, possibly
// another clock domain, and a one-cycle-read register port master.
`timescale 1ns/1ps
`include "usb_ep_irq_defines.vh"

module usb_endpoint_interrupt_summary #(
   parameter EPS  = `EP_COUNT,
   parameter SRCS = `EP_SRC_COUNT
) (
   input  wire                   clock_i,
   input  wire                   rst_n_i,
   input  wire [EPS*SRCS-1:0]    ep_sources_i,
   input  wire [`ADDR_WIDTH-1:0] addr_i,
   input  wire [`REG_WIDTH-1:0]  wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [`REG_WIDTH-1:0]  rdata_o,
   output reg                    usb_irq_o,
   output reg                    event_irq_o,
   output reg  [EPS-1:0]         ep_pending_o
);

   // -------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------
   reg rst_meta_r;
   reg rst_sync_r;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // -------------------------------------------------------------------
   // Source synchronisers
   // -------------------------------------------------------------------
   // Sources are levels, so a plain two-stage synchroniser is enough;
   // a source shorter than one clock may be missed, which is acceptable
   // because the status block holds them until software clears them.
   reg [EPS*SRCS-1:0] src_meta_r;
   reg [EPS*SRCS-1:0] src_sync_r;
   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         src_meta_r <= {EPS*SRCS{1'b0}};
         src_sync_r <= {EPS*SRCS{1'b0}};
      end else begin
         src_meta_r <= ep_sources_i;
         src_sync_r <= src_meta_r;
      end
   end

   // -------------------------------------------------------------------
   // Summary flags
   // -------------------------------------------------------------------
   wire [EPS-1:0] pending_nxt;
   reg  [EPS-1:0] pending_r;

   ep_summary_or #(
      .EPS  (EPS),
      .SRCS (SRCS)
   ) u_or (
      .sources_i (src_sync_r),
      .pending_o (pending_nxt)
   );

   // Reloaded every cycle, so the flag falls as soon as all sources go.
   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pending_r <= {EPS{1'b0}};
      end else begin
         pending_r <= pending_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Enable registers
   // -------------------------------------------------------------------
   reg  [EPS-1:0] ep_enable_r;
   reg  [EPS-1:0] irq_enable_r;
   wire wr_ep_enable  = wr_i && (addr_i == `OFS_EP_ENABLE);
   wire wr_irq_enable = wr_i && (addr_i == `OFS_IRQ_ENABLE);
   wire wr_irq_clear  = wr_i && (addr_i == `OFS_IRQ_CLEAR);

   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ep_enable_r  <= `RST_EP_ENABLE;
         irq_enable_r <= `RST_IRQ_ENABLE;
      end else begin
         if (wr_ep_enable) begin
            ep_enable_r <= wdata_i[EPS-1:0];
         end
         if (wr_irq_enable) begin
            irq_enable_r <= wdata_i[EPS-1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Event status: rising edge of each summary flag
   // -------------------------------------------------------------------
   reg  [EPS-1:0] pending_d_r;
   wire [EPS-1:0] rise = pending_r & ~pending_d_r;
   wire [EPS-1:0] irq_status;
   wire [EPS-1:0] clear_mask = wr_irq_clear ? wdata_i[EPS-1:0]
                                            : {EPS{1'b0}};

   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pending_d_r <= {EPS{1'b0}};
      end else begin
         pending_d_r <= pending_r;
      end
   end

   sticky_status #(
      .W (EPS)
   ) u_sticky (
      .clock_i  (clock_i),
      .rst_n_i  (rst_sync_r),
      .set_i    (rise),
      .clear_i  (clear_mask),
      .status_o (irq_status)
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         usb_irq_o    <= 1'b0;
         event_irq_o  <= 1'b0;
         ep_pending_o <= {EPS{1'b0}};
      end else begin
         usb_irq_o    <= |(pending_nxt & ep_enable_r);
         event_irq_o  <= |(irq_status & irq_enable_r);
         ep_pending_o <= pending_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Register read port
   // -------------------------------------------------------------------
   function [`REG_WIDTH-1:0] pad;
      input [EPS-1:0] v;
      begin
         pad = {`REG_WIDTH{1'b0}};
         pad[EPS-1:0] = v;
      end
   endfunction

   always @(posedge clock_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rdata_o <= {`REG_WIDTH{1'b0}};
      end else if (rd_i) begin
         case (addr_i)
            `OFS_EP_SUMMARY: rdata_o <= pad(pending_r);
            `OFS_EP_ENABLE:  rdata_o <= pad(ep_enable_r);
            `OFS_IRQ_STATUS: rdata_o <= pad(irq_status);
            `OFS_IRQ_ENABLE: rdata_o <= pad(irq_enable_r);
            default:         rdata_o <= {`REG_WIDTH{1'b0}};
         endcase
      end else begin
         rdata_o <= {`REG_WIDTH{1'b0}};
      end
   end

endmodule // usb_endpoint_interrupt_summary

// ### usb_ep_irq_defines.vh
// Constants of the endpoint interrupt summary block.
// Included by the top design file of the block only; definitions only.
`ifndef USB_EP_IRQ_DEFINES_VH
`define USB_EP_IRQ_DEFINES_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define EP_COUNT            6
`define EP_SRC_COUNT        5
`define REG_WIDTH           8
`define ADDR_WIDTH          4

// ----------------------------------------------------------------------
// Source positions within one endpoint's status word
// ----------------------------------------------------------------------
`define SRC_TX_COMPLETE     0
`define SRC_RX_BANK_ZERO    1
`define SRC_RX_BANK_ONE     2
`define SRC_SETUP_RECEIVED  3
`define SRC_STALL_CRC       4

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_EP_SUMMARY      4'h0
`define OFS_EP_ENABLE       4'h1
`define OFS_IRQ_STATUS      4'h2
`define OFS_IRQ_CLEAR       4'h3
`define OFS_IRQ_ENABLE      4'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_EP_ENABLE       6'h00
`define RST_IRQ_ENABLE      6'h00

`endif

// ### ep_summary_or.v
// Per-endpoint OR of the interrupt sources into summary flags.
// Sources arrive already synchronised to the system clock.
`timescale 1ns/1ps

module ep_summary_or #(
   parameter EPS  = 6,
   parameter SRCS = 5
) (
   input  wire [EPS*SRCS-1:0] sources_i,
   output reg  [EPS-1:0]      pending_o
);

   integer e;

   always @* begin
      pending_o = {EPS{1'b0}};
      for (e = 0; e < EPS; e = e + 1) begin
         pending_o[e] = |sources_i[e*SRCS +: SRCS];
      end
   end

endmodule // ep_summary_or

// ### sticky_status.v
// Sticky event bits with write-one-to-clear; set wins over clear.
// Runs on the system clock with the synchronised reset.
`timescale 1ns/1ps

module sticky_status #(
   parameter W = 6
) (
   input  wire         clock_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] set_i,
   input  wire [W-1:0] clear_i,
   output reg  [W-1:0] status_o
);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_o <= {W{1'b0}};
      end else begin
         status_o <= (status_o & ~clear_i) | set_i;
      end
   end

endmodule // sticky_status

// ### ep_irq_sva.sv
// Port checker of the endpoint interrupt summary block.
// Assumes one clock domain and bind to the top module.
`timescale 1ns/1ps
module ep_irq_sva #(
   parameter EPS  = 6,
   parameter SRCS = 5
) (
   input wire                clock_i,
   input wire                rst_n_i,
   input wire [EPS*SRCS-1:0] ep_sources_i,
   input wire [3:0]          addr_i,
   input wire [7:0]          wdata_i,
   input wire                wr_i,
   input wire                rd_i,
   input wire [7:0]          rdata_o,
   input wire                usb_irq_o,
   input wire                event_irq_o,
   input wire [EPS-1:0]      ep_pending_o
);
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   logic [EPS-1:0] any_src;
   always_comb begin
      for (int e = 0; e < EPS; e++) any_src[e] = |ep_sources_i[e*SRCS+:SRCS];
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence en_all_s;
      wr_i && addr_i == 4'h1 && wdata_i[5:0] == 6'h3F;
   endsequence
   sequence held_s;
      (|ep_pending_o) [*2];
   endsequence
   a_rsvd_zero: assert property (rdata_o[7:6] == 2'h0)
      else $error("reserved bits set");
   a_flag_follow: assert property (
      ep_pending_o == $past(any_src, 3))
      else $error("flag not source level");
   a_summary_read: assert property ($past(rd_i && addr_i == 4'h0) |->
      rdata_o[EPS-1:0] == $past(ep_pending_o))
      else $error("summary read wrong");
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read");
   a_unmapped_zero: assert property ($past(rd_i && addr_i > 4'h4) |->
      rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_irq_flag: assert property (usb_irq_o |-> |ep_pending_o)
      else $error("irq without flag");
   a_irq_enable: assert property (
      en_all_s ##1 held_s |-> usb_irq_o)
      else $error("enabled flag gives no irq");
   a_enable_off: assert property (wr_i && addr_i == 4'h1 &&
      wdata_i[5:0] == 6'h00 |-> ##2 !usb_irq_o)
      else $error("irq while disabled");
endmodule // ep_irq_sva

bind usb_endpoint_interrupt_summary ep_irq_sva #(
   .EPS(EPS), .SRCS(SRCS)) u_sva (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .ep_sources_i(ep_sources_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .usb_irq_o(usb_irq_o), .event_irq_o(event_irq_o),
   .ep_pending_o(ep_pending_o));

// ### usb_endpoint_interrupt_summary_tb.sv
// Self-checking bench of the endpoint interrupt summary block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module usb_endpoint_interrupt_summary_tb;
   reg         clock_i = 0;
   reg         rst_n_i = 0;
   reg  [29:0] src = 0, h1 = 0, h2 = 0, h3 = 0;
   reg  [3:0]  addr = 0;
   reg  [7:0]  wd = 0, v;
   reg         wr = 0, rd = 0, rdq = 0, ron = 0;
   reg  [5:0]  ep = 0;
   reg  [31:0] lf = 32'h9492;
   wire [7:0]  rdata;
   wire        uirq, eirq;
   wire [5:0]  pend;
   integer     mismatches = 0, comparisons = 0, cyc = 0, i;
   usb_endpoint_interrupt_summary dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .ep_sources_i(src), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .usb_irq_o(uirq), .event_irq_o(eirq),
      .ep_pending_o(pend));
   // -------------------------------------------------------------
   // Model and helpers
   // -------------------------------------------------------------
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [5:0] orf(input [29:0] s);
      integer e;
      for (e = 0; e < 6; e = e + 1) orf[e] = |s[e*5+:5];
   endfunction
   task chk(input [7:0] s, input [7:0] e);
      comparisons = comparisons + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task wrt(input [3:0] a, input [7:0] d);
      @(posedge clock_i) {addr, wd, wr} <= {a, d, 1'b1};
      @(posedge clock_i) wr <= 1'b0;
      #1;
   endtask
   task rdr(input [3:0] a, output [7:0] d);
      @(posedge clock_i) {addr, rd} <= {a, 1'b1};
      @(posedge clock_i) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Sources pass three edges before the flags show them.
   initial forever #5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      {h1, h2, h3} <= {src, h1, h2};
      rdq <= rd && addr == 4'h0;
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end
   always @(negedge clock_i) if (rst_n_i) begin
      chk({2'h0, pend}, {2'h0, orf(h3)});
      if (ron && rdq) chk(rdata, {2'h0, ep});
      ep = orf(h3);
   end
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      ron = 1;
      for (i = 0; i < 400; i = i + 1) begin
         @(posedge clock_i);
         lf = lfsr(lf);
         src <= lf[29:0] & {lf[14:0], lf[31:17]};
         {addr, rd} <= {4'h0, lf[31]};
      end
      @(posedge clock_i) {src, rd} <= 0;
      ron = 0;
      repeat (5) @(posedge clock_i);
      wrt(4'h1, 8'h3F);
      rdr(4'h1, v);
      chk(v, 8'h3F);
      @(posedge clock_i) src <= 30'h4000;
      wrt(4'h0, 8'h00);
      repeat (3) @(posedge clock_i);
      rdr(4'h0, v);
      chk(v, 8'h04);
      chk({7'h0, uirq}, 8'h01);
      // The request register is loaded one edge after the enable write.
      wrt(4'h1, 8'h3B);
      @(posedge clock_i) #1 chk({7'h0, uirq}, 8'h00);
      wrt(4'h1, 8'h3F);
      @(posedge clock_i) #1 chk({7'h0, uirq}, 8'h01);
      @(posedge clock_i) src <= 0;
      repeat (4) @(posedge clock_i);
      #1 chk({7'h0, uirq}, 8'h00);
      wrt(4'h1, 8'h00);
      wrt(4'h3, 8'h3F);
      rdr(4'h2, v);
      chk(v, 8'h00);
      wrt(4'h4, 8'h01);
      @(posedge clock_i) src <= 30'h1;
      repeat (6) @(posedge clock_i);
      #1 chk({7'h0, eirq}, 8'h01);
      rdr(4'h2, v);
      chk(v, 8'h01);
      wrt(4'h4, 8'h00);
      @(posedge clock_i) #1 chk({7'h0, eirq}, 8'h00);
      @(posedge clock_i) src <= 0;
      repeat (4) @(posedge clock_i);
      wrt(4'h3, 8'h01);
      wrt(4'h4, 8'h01);
      @(posedge clock_i) #1 chk({7'h0, eirq}, 8'h00);
      for (i = 3; i < 16; i = i + 1) begin
         if (i != 4) rdr(i[3:0], v);
         if (i != 4) chk(v, 8'h00);
      end
      summarize;
   end
endmodule // usb_endpoint_interrupt_summary_tb
